// ---- srst_top.sv ----
// System reset controller: source combiner, cause flags, register port and stretch control
// How it works
// RQ1: Internal reset reloads all peripheral registers.
// RQ2: Fetch from reset vector on release.
// RQ3: Port pins reset at once, clockless.
// RQ4: Hold reset while sources active, then stretch.
// RQ5: Stretch length comes from start-up fuses.
// RQ6: Exactly five reset sources combined.
// RQ7: Power-on detect asserts reset.
// RQ8: Pin low beyond minimum width resets.
// RQ9: Watchdog expiry resets only when enabled. port_reset_o takes the raw timeout without the enable.
// RQ10: Brown-out resets only when detector enabled.
// RQ11: Debug register one holds reset.
// RQ12: Watchdog pulse one cycle; stretch starts after.
// RQ13: Cause flags at bits four to zero.
// RQ14: Power-on clears flags; power flag software-only.
// RQ15: Assert asynchronously, release on clock edge. Pin, watchdog and debug assert int_reset_o only after the clocked sampler.
//
// Local design decisions: the plain strobed port and the address map.
`include "srst_regs.svh"
module srst_top
  import srst_pkg::*;
#(
  parameter srst_count_t TOUT_SEL0_CYC = 24'd16,
  parameter srst_count_t TOUT_SEL1_CYC = 24'd512,
  parameter srst_count_t TOUT_SEL2_CYC = 24'd4096,
  parameter srst_count_t TOUT_SEL3_CYC = 24'd8192,
  parameter srst_count_t OSC_START_CYC = 24'd1024,
  parameter logic [15:0] RESET_VECTOR = 16'h0000
) (
  // Clock and block reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Reset sources, asynchronous to clk_sys_i
  input wire logic por_low_i,
  input wire logic reset_pin_n_i,
  input wire logic wdt_timeout_i,
  input wire logic bod_low_i,
  input wire logic debug_reset_instruction_i,
  // Enables and fuses, static or on clk_sys_i
  input wire logic wdt_enable_i,
  input wire logic bod_enable_i,
  input wire logic [1:0] startup_time_select_i,
  input wire logic [3:0] clock_source_select_i,
  // Register port
  input wire logic [7:0] bus_addr_i,
  input wire logic [7:0] bus_wdata_i,
  input wire logic bus_write_i,
  input wire logic bus_read_i,
  output logic [7:0] bus_rdata_o,
  // Reset outputs
  output logic port_reset_o,
  output logic int_reset_o,
  output logic cpu_fetch_o,
  output logic [15:0] fetch_addr_o,
  // Interrupt
  output logic irq_o
);
  localparam logic [SRST_PIN_CNT_W-1:0] PIN_MIN = SRST_PIN_CNT_W'(`SRST_PIN_MIN_CYC);

  srst_main_state_t st_reg;
  srst_main_state_t st_next;
  srst_dly_if dif ();

  logic por_s;
  logic pin_low_s;
  logic wdt_s;
  logic bod_s;
  logic dbg_s;
  logic pin_req;
  logic bod_req;
  logic src_active;
  logic wr_cause;
  srst_count_t tout_cycles;
  logic [4:0] cause_set;
  logic [1:0] irq_event;

  // Only the second stage of each synchroniser is read
  assign por_s = st_reg.por_sync[1];
  assign pin_low_s = ~st_reg.pin_sync[1];
  assign wdt_s = st_reg.wdt_sync[1];
  assign bod_s = st_reg.bod_sync[1];
  assign dbg_s = st_reg.dbg_sync[1];

  assign pin_req = pin_low_s && (st_reg.pin_cnt == PIN_MIN); // [RQ8]
  assign bod_req = bod_s & bod_enable_i; // [RQ10]
  // Five sources and no more feed the combined request
  assign src_active = por_s | pin_req | st_reg.wdt_pulse | bod_req | dbg_s; // [RQ6] [RQ7] [RQ11]

  // Stretch length from the start-up fuses; any clock source other than the external clock adds oscillator start-up
  always_comb begin
    case (startup_time_select_i)
      2'h0: tout_cycles = TOUT_SEL0_CYC; // [RQ5]
      2'h1: tout_cycles = TOUT_SEL1_CYC;
      2'h2: tout_cycles = TOUT_SEL2_CYC;
      2'h3: tout_cycles = TOUT_SEL3_CYC;
      default: tout_cycles = TOUT_SEL3_CYC;
    endcase
    if (clock_source_select_i != `SRST_CLOCK_SOURCE_SELECT_EXT_CLK) begin
      tout_cycles = tout_cycles + OSC_START_CYC; // [RQ5]
    end
  end

  assign dif.src_active = src_active;
  assign dif.load_cycles = tout_cycles;

  srst_delay u_delay (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .dly(dif.delay)
  );

  // Pins see the raw sources with no clock in the path; the pin is unfiltered here on purpose
  assign port_reset_o = por_low_i | ~reset_pin_n_i | wdt_timeout_i | (bod_low_i & bod_enable_i)
                        | debug_reset_instruction_i; // [RQ3]
  // Supply detectors assert at once; release waits for the stretch counter edge
  assign int_reset_o = por_low_i | (bod_low_i & bod_enable_i) | dif.busy; // [RQ15] [RQ4] [RQ7] [RQ10]

  assign wr_cause = bus_write_i && (bus_addr_i == `SRST_ADDR_CAUSE);

  always_comb begin
    cause_set = '0;
    cause_set[`SRST_BIT_DEBUG] = dbg_s; // [RQ13]
    cause_set[`SRST_BIT_WDOG] = st_reg.wdt_pulse;
    cause_set[`SRST_BIT_BROWN] = bod_req;
    cause_set[`SRST_BIT_PIN] = pin_req;
    cause_set[`SRST_BIT_POWER] = por_s;
    irq_event = '0;
    irq_event[`SRST_IRQ_PIN_GLITCH] = !pin_low_s && (st_reg.pin_cnt != '0) && (st_reg.pin_cnt != PIN_MIN);
    irq_event[`SRST_IRQ_WDOG_IGNORED] = wdt_s && !st_reg.wdt_prev && !wdt_enable_i;
  end

  always_comb begin
    st_next = st_reg;
    st_next.por_sync = {st_reg.por_sync[0], por_low_i};
    st_next.pin_sync = {st_reg.pin_sync[0], reset_pin_n_i};
    st_next.wdt_sync = {st_reg.wdt_sync[0], wdt_timeout_i};
    st_next.bod_sync = {st_reg.bod_sync[0], bod_low_i};
    st_next.dbg_sync = {st_reg.dbg_sync[0], debug_reset_instruction_i};
    st_next.wdt_prev = wdt_s;
    // One-cycle pulse on a timeout edge; stretch starts when it ends
    st_next.wdt_pulse = wdt_s && !st_reg.wdt_prev && wdt_enable_i; // [RQ9] [RQ12]
    // Minimum-width filter on the external pin
    if (!pin_low_s) begin
      st_next.pin_cnt = '0;
    end else if (st_reg.pin_cnt != PIN_MIN) begin
      st_next.pin_cnt = st_reg.pin_cnt + SRST_PIN_CNT_W'(1); // [RQ8]
    end
    // Cause flags: write zero clears, power-on clears the upper four, a set always wins
    st_next.cause = st_reg.cause;
    if (wr_cause) begin
      st_next.cause = st_reg.cause & bus_wdata_i[4:0]; // [RQ14]
    end
    if (por_s) begin
      st_next.cause[4:1] = 4'h0; // [RQ14]
    end
    st_next.cause = st_next.cause | cause_set; // [RQ13]
    // Interrupt status: write one clears, event wins
    if (bus_write_i && (bus_addr_i == `SRST_ADDR_IRQ_STAT)) begin
      st_next.irq_stat = st_reg.irq_stat & ~bus_wdata_i[1:0];
    end
    st_next.irq_stat = st_next.irq_stat | irq_event;
    if (bus_write_i && (bus_addr_i == `SRST_ADDR_IRQ_MASK)) begin
      st_next.irq_mask = bus_wdata_i[1:0];
    end
    // Peripheral registers stay at initial values throughout internal reset
    if (int_reset_o) begin
      st_next.irq_stat = `SRST_IRQ_RST; // [RQ1]
      st_next.irq_mask = `SRST_IRQ_RST; // [RQ1]
    end
    // Read data stand one cycle after the strobe; unmapped reads zero
    st_next.rdata = `SRST_RDATA_RST;
    if (bus_read_i) begin
      case (bus_addr_i)
        `SRST_ADDR_CAUSE: st_next.rdata = {3'h0, st_reg.cause};
        `SRST_ADDR_IRQ_STAT: st_next.rdata = {6'h00, st_reg.irq_stat};
        `SRST_ADDR_IRQ_MASK: st_next.rdata = {6'h00, st_reg.irq_mask};
        `SRST_ADDR_LIVE: st_next.rdata = {2'h0, dif.busy, dbg_s, st_reg.wdt_pulse, bod_req, pin_req, por_s};
        default: st_next.rdata = `SRST_RDATA_RST;
      endcase
    end
    st_next.int_rst_d = int_reset_o;
    st_next.fetch = st_reg.int_rst_d && !int_reset_o; // [RQ2]
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      st_reg.por_sync <= 2'h0;
      st_reg.pin_sync <= 2'h3;
      st_reg.wdt_sync <= 2'h0;
      st_reg.bod_sync <= 2'h0;
      st_reg.dbg_sync <= 2'h0;
      st_reg.wdt_prev <= 1'b0;
      st_reg.wdt_pulse <= 1'b0;
      st_reg.pin_cnt <= '0;
      st_reg.cause <= `SRST_CAUSE_RST;
      st_reg.irq_stat <= `SRST_IRQ_RST;
      st_reg.irq_mask <= `SRST_IRQ_RST;
      st_reg.rdata <= `SRST_RDATA_RST;
      st_reg.int_rst_d <= 1'b1;
      st_reg.fetch <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign bus_rdata_o = st_reg.rdata;
  assign irq_o = |(st_reg.irq_stat & st_reg.irq_mask);
  assign cpu_fetch_o = st_reg.fetch; // [RQ2]
  assign fetch_addr_o = RESET_VECTOR; // [RQ2]

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  sequence s_fetch_once;
    cpu_fetch_o ##1 !cpu_fetch_o;
  endsequence
  sequence s_wdt_fire;
    st_reg.wdt_pulse ##1 !st_reg.wdt_pulse;
  endsequence

  chk_periph_held_initial: assert property (int_reset_o && $past(int_reset_o) |->
    st_reg.irq_stat == `SRST_IRQ_RST && st_reg.irq_mask == `SRST_IRQ_RST && !irq_o) // [RQ1]
    else $error("peripheral register left its initial value during reset");
  chk_fetch_on_release: assert property ($fell(int_reset_o) |=> s_fetch_once) // [RQ2]
    else $error("no single fetch pulse after reset release");
  // Raw levels: the synced copies lag the pins by two edges, so the port reset may already have dropped
  chk_port_reset_now: assert property (por_low_i || !reset_pin_n_i || debug_reset_instruction_i |-> port_reset_o) // [RQ3]
    else $error("port pins not reset while a source is active");
  chk_hold_while_src: assert property (src_active |-> int_reset_o) // [RQ4] [RQ6] [RQ11]
    else $error("internal reset dropped while a source is active");
  chk_release_clocked: assert property ($fell(int_reset_o) |-> $past(dif.count) == srst_count_t'(1)
    && !$past(src_active)) // [RQ15]
    else $error("internal reset released off the stretch count");
  chk_pin_min_width: assert property (pin_req |-> $past(pin_low_s) && st_reg.pin_cnt == PIN_MIN) // [RQ8]
    else $error("pin reset taken before the minimum width");
  chk_wdt_gated_pulse: assert property (st_reg.wdt_pulse |-> $past(wdt_enable_i) ##0 s_wdt_fire) // [RQ9] [RQ12]
    else $error("watchdog reset pulse not one cycle or not gated");
  chk_wdt_stretch_start: assert property (s_wdt_fire |-> dif.count == tout_cycles || src_active) // [RQ12]
    else $error("stretch did not start as the watchdog pulse ended");
  chk_bod_gated: assert property (bod_s && !bod_enable_i |-> !cause_set[`SRST_BIT_BROWN]) // [RQ10]
    else $error("disabled brown-out detector raised a reset");
  chk_cause_wdog_set: assert property (st_reg.wdt_pulse |=> st_reg.cause[`SRST_BIT_WDOG]) // [RQ13]
    else $error("watchdog cause flag not set");
  chk_power_flag_kept: assert property (st_reg.cause[`SRST_BIT_POWER] && !wr_cause |=>
    st_reg.cause[`SRST_BIT_POWER]) // [RQ14]
    else $error("power-on flag cleared without a software write");
  chk_por_clears_upper: assert property (por_s && !dbg_s && !st_reg.wdt_pulse && !bod_req && !pin_req
    |=> st_reg.cause[4:1] == 4'h0) // [RQ14]
    else $error("power-on did not clear the other cause flags");
  chk_por_asserts: assert property (por_s |-> int_reset_o ##1 int_reset_o) // [RQ7]
    else $error("power-on detect did not hold reset");
endmodule // srst_top

// ---- srst_regs.svh ----
// Register offsets, field positions, reset values and timing counts of the system reset controller
`ifndef SRST_REGS_SVH
`define SRST_REGS_SVH
`define SRST_ADDR_CAUSE 8'h00
`define SRST_ADDR_IRQ_STAT 8'h04
`define SRST_ADDR_IRQ_MASK 8'h08
`define SRST_ADDR_LIVE 8'h0C
`define SRST_BIT_DEBUG 4
`define SRST_BIT_WDOG 3
`define SRST_BIT_BROWN 2
`define SRST_BIT_PIN 1
`define SRST_BIT_POWER 0
`define SRST_IRQ_PIN_GLITCH 0
`define SRST_IRQ_WDOG_IGNORED 1
`define SRST_CAUSE_RST 5'h00
`define SRST_IRQ_RST 2'h0
`define SRST_RDATA_RST 8'h00
`define SRST_CLOCK_SOURCE_SELECT_EXT_CLK 4'h0
`define SRST_CLK_PERIOD_PS 8000
`define SRST_PIN_MIN_NS 400
`define SRST_PIN_MIN_CYC ((`SRST_PIN_MIN_NS * 1000 + `SRST_CLK_PERIOD_PS - 1) / `SRST_CLK_PERIOD_PS)
`endif

// ---- srst_pkg.sv ----
// Types shared by the system reset controller modules
package srst_pkg;
  localparam int SRST_CNT_W = 24;
  localparam int SRST_PIN_CNT_W = 7;
  typedef logic [SRST_CNT_W-1:0] srst_count_t;
  typedef struct packed {
    logic [1:0] por_sync;
    logic [1:0] pin_sync;
    logic [1:0] wdt_sync;
    logic [1:0] bod_sync;
    logic [1:0] dbg_sync;
    logic wdt_prev;
    logic wdt_pulse;
    logic [SRST_PIN_CNT_W-1:0] pin_cnt;
    logic [4:0] cause;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    logic [7:0] rdata;
    logic int_rst_d;
    logic fetch;
  } srst_main_state_t;
  typedef struct packed {
    srst_count_t count;
  } srst_delay_state_t;
endpackage

// ---- srst_dly_if.sv ----
// Link between the source combiner and the reset stretch counter
interface srst_dly_if;
  import srst_pkg::*;
  logic src_active;
  srst_count_t load_cycles;
  logic busy;
  srst_count_t count;
  modport ctrl (output src_active, output load_cycles, input busy, input count);
  modport delay (input src_active, input load_cycles, output busy, output count);
endinterface

// ---- srst_delay.sv ----
// Reset stretch counter reloaded while any source is active
module srst_delay
  import srst_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Combiner side
  srst_dly_if.delay dly
);
  srst_delay_state_t st_reg;
  srst_delay_state_t st_next;

  always_comb begin
    st_next = st_reg;
    if (dly.src_active) begin
      st_next.count = dly.load_cycles; // [RQ4] [RQ5]
    end else if (st_reg.count != '0) begin
      st_next.count = st_reg.count - srst_count_t'(1); // [RQ4]
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      st_reg.count <= '1;
    end else begin
      st_reg <= st_next;
    end
  end

  // Busy drops on the clock edge at which the count empties
  assign dly.busy = dly.src_active | (st_reg.count != '0); // [RQ15]
  assign dly.count = st_reg.count;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  chk_delay_load_len: assert property ($fell(dly.src_active) |-> st_reg.count == $past(dly.load_cycles)) // [RQ5]
    else $error("stretch count not loaded from the selected time-out");
  chk_delay_counts_down: assert property (!dly.src_active && st_reg.count != '0 |=>
    st_reg.count == $past(st_reg.count) - srst_count_t'(1) || dly.src_active) // [RQ4]
    else $error("stretch counter did not step down");
endmodule // srst_delay

// ---- srst_src_model.sv ----
// Behavioural model of the reset sources that drive the controller
module srst_src_model (
  // Clock
  input wire logic clk_sys_i,
  // Bench requests: power-on, pin, brown-out, watchdog, debug
  input wire logic [4:0] req_i,
  // Source lines
  output logic por_low_o,
  output logic reset_pin_n_o,
  output logic wdt_timeout_o,
  output logic bod_low_o,
  output logic debug_reset_instruction_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic wdt_req_reg = 1'b0;
  logic [1:0] wdt_hold_reg = 2'h0;
  // Detectors are level outputs with no clock of their own
  assign por_low_o = req_i[0];
  assign reset_pin_n_o = ~req_i[1];
  assign bod_low_o = req_i[2];
  // Scan-chain register keeps its one until the host loads a zero
  assign debug_reset_instruction_o = req_i[4];
  // Expiry strobe held three cycles so the two-stage sampler cannot miss it
  assign wdt_timeout_o = (wdt_hold_reg != 2'h0);
  always @(posedge clk_sys_i) begin
    wdt_req_reg <= req_i[3];
    if (req_i[3] && !wdt_req_reg) begin
      wdt_hold_reg <= 2'h3;
    end else if (wdt_hold_reg != 2'h0) begin
      wdt_hold_reg <= wdt_hold_reg - 2'h1;
    end
  end
endmodule // srst_src_model

// ---- system_reset_control_tb.sv ----
// Self-checking testbench of the system reset controller
module system_reset_control_tb import srst_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam srst_count_t OSC = 24'd16;
  localparam srst_count_t TS [4] = '{24'd4, 24'd28, 24'd52, 24'd76};
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic [4:0] req = 5'h01;
  logic por_low_i, reset_pin_n_i, wdt_timeout_i, bod_low_i, debug_reset_instruction_i;
  logic wdt_enable_i = 1'b0;
  logic bod_enable_i = 1'b0;
  logic [1:0] startup_time_select_i = 2'h0;
  logic [3:0] clock_source_select_i = 4'h0;
  logic [7:0] bus_addr_i = 8'h00;
  logic [7:0] bus_wdata_i = 8'h00;
  logic bus_write_i = 1'b0;
  logic bus_read_i = 1'b0;
  logic rd_d = 1'b0;
  logic [7:0] bus_rdata_o;
  logic port_reset_o, int_reset_o, cpu_fetch_o, irq_o;
  logic [15:0] fetch_addr_o;
  logic [7:0] exp_q [$];
  int mismatches = 0;
  int n_checks = 0;
  always #4 clk_sys_i = ~clk_sys_i;
  srst_src_model srst_src_model_inst (.clk_sys_i, .req_i(req), .por_low_o(por_low_i), .reset_pin_n_o(reset_pin_n_i),
    .wdt_timeout_o(wdt_timeout_i), .bod_low_o(bod_low_i), .debug_reset_instruction_o(debug_reset_instruction_i));
  srst_top #(.TOUT_SEL0_CYC(TS[0]), .TOUT_SEL1_CYC(TS[1]), .TOUT_SEL2_CYC(TS[2]), .TOUT_SEL3_CYC(TS[3]),
    .OSC_START_CYC(OSC)) srst_top_inst (.clk_sys_i, .rst_i, .por_low_i, .reset_pin_n_i, .wdt_timeout_i, .bod_low_i,
    .debug_reset_instruction_i, .wdt_enable_i, .bod_enable_i, .startup_time_select_i, .clock_source_select_i,
    .bus_addr_i, .bus_wdata_i, .bus_write_i, .bus_read_i, .bus_rdata_o, .port_reset_o, .int_reset_o, .cpu_fetch_o,
    .fetch_addr_o, .irq_o);
  task automatic check(string what, logic [23:0] seen, logic [23:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic cyc(int n);
    repeat (n) @(negedge clk_sys_i);
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge clk_sys_i);
    bus_addr_i <= a;
    bus_wdata_i <= d;
    bus_write_i <= 1'b1;
    @(posedge clk_sys_i);
    bus_write_i <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e);
    @(posedge clk_sys_i);
    exp_q.push_back(e);
    bus_addr_i <= a;
    bus_read_i <= 1'b1;
    @(posedge clk_sys_i);
    bus_read_i <= 1'b0;
  endtask
  // Holds one source for n cycles and checks the reset level just before release
  task automatic pulse(int b, int n, logic lvl);
    @(posedge clk_sys_i);
    req[b] <= 1'b1;
    cyc(n);
    check("held", 24'(int_reset_o), 24'(lvl));
    @(posedge clk_sys_i);
    req[b] <= 1'b0;
  endtask
  function automatic int tlen();
    return int'(TS[startup_time_select_i]) + ((clock_source_select_i != 4'h0) ? int'(OSC) : 0);
  endfunction
  // Window allows for the two sampler stages and the watchdog pulse
  task automatic stretch(int len);
    int n = 0;
    logic f = 1'b0;
    do begin
      @(negedge clk_sys_i);
      n++;
    end while (int_reset_o !== 1'b0 && n < 300);
    repeat (3) begin
      f = f | cpu_fetch_o;
      @(negedge clk_sys_i);
    end
    check("stretch", 24'(n >= len - 4 && n <= len + 8), 24'h1);
    check("fetch", 24'(f), 24'h1);
    check("vector", 24'(fetch_addr_o), 24'h0);
  endtask
  always @(posedge clk_sys_i) begin
    if (rd_d) begin
      check("rdata", 24'(bus_rdata_o), 24'(exp_q.pop_front()));
    end
    rd_d <= bus_read_i;
  end
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    mismatches++;
    results();
  end
  initial begin
    void'($urandom(63));
    #1;
    check("port_reset", 24'(port_reset_o), 24'h1);
    check("int_reset", 24'(int_reset_o), 24'h1);
    repeat (10) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    cyc(4);
    wr(8'h08, 8'hFF);
    rd(8'h08, 8'h00);
    rd(8'h00, 8'h01);
    req[0] <= 1'b0;
    stretch(tlen());
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys_i);
      startup_time_select_i <= 2'(i);
      clock_source_select_i <= (i % 2 == 1) ? 4'($urandom_range(15, 1)) : 4'h0;
      pulse(4, 20, 1'b1);
      stretch(tlen());
    end
    rd(8'h00, 8'h11);
    wr(8'h00, 8'hFF);
    rd(8'h00, 8'h11);
    wr(8'h00, 8'h00);
    rd(8'h00, 8'h00);
    wr(8'h08, 8'h03);
    pulse(1, 20, 1'b0);
    cyc(4);
    check("irq", 24'(irq_o), 24'h1);
    rd(8'h04, 8'h01);
    wr(8'h04, 8'h01);
    cyc(1);
    check("irq", 24'(irq_o), 24'h0);
    pulse(1, 60, 1'b1);
    stretch(tlen());
    wr(8'h08, 8'h01);
    pulse(3, 1, 1'b0);
    cyc(8);
    check("irq", 24'(int_reset_o | irq_o), 24'h0);
    rd(8'h04, 8'h02);
    @(posedge clk_sys_i);
    wdt_enable_i <= 1'b1;
    pulse(3, 1, 1'b0);
    cyc(6);
    check("int_reset", 24'(int_reset_o), 24'h1);
    stretch(tlen());
    rd(8'h00, 8'h0A);
    pulse(2, 10, 1'b0);
    @(posedge clk_sys_i);
    bod_enable_i <= 1'b1;
    pulse(2, 10, 1'b1);
    stretch(tlen());
    rd(8'h00, 8'h0E);
    wr(8'h00, 8'h0E);
    rd(8'h00, 8'h0E);
    pulse(0, 5, 1'b1);
    stretch(tlen());
    rd(8'h00, 8'h01);
    wr(8'h10, 8'($urandom));
    rd(8'h10, 8'h00);
    wr(8'h0C, 8'hFF);
    rd(8'h0C, 8'h00);
    cyc(4);
    check("queue", 24'(exp_q.size()), 24'h0);
    results();
  end
endmodule // system_reset_control_tb
